// ---- design/sdl_loader.sv ----
// Serial input, latch and output update of the word loader
`timescale 1ns/1ps
module sdl_loader
	import sdl_pkg::*;
(
	input  wire logic                 clk,
	input  wire logic                 rst_b,
	input  wire logic                 bit_clk,
	input  wire logic                 serial_data,
	input  wire logic                 latch_strobe,
	output logic      [WORD_BITS-1:0] current_output,
	output logic      [HALF_BITS:0]   lower_code,
	output logic      [HALF_BITS-1:0] upper_code,
	output logic                      update_pulse,
	input  wire logic                 sink_ready,
	output logic                      word_dropped
);
	// The split and the update counter are sized by these constants
	if (WORD_BITS != HALF_BITS + 1) begin : g_bad_split
		$error("WORD_BITS must exceed HALF_BITS by one");
	end
	if (UPDATE_CLOCKS < 1 || UPDATE_CLOCKS > (1 << CNT_BITS)) begin : g_bad_count
		$error("UPDATE_CLOCKS does not fit the rise counter");
	end

	// Pin synchronisers
	logic [1:0] bclk_s_q;
	logic [1:0] data_s_q;
	logic [1:0] le_s_q;
	logic       bclk_q;
	logic       le_q;
	logic       data_q;

	logic [WORD_BITS-1:0] shift_q;
	logic [WORD_BITS-1:0] latched_q;
	logic [CNT_BITS-1:0]  rise_cnt_q;
	sdl_state_t           state_q;
	logic                 buf_in_ready;
	logic                 buf_out_valid;
	sdl_codes_t           buf_out;
	logic [WORD_BITS-1:0] out_q;
	logic                 upd_q;
	logic                 drop_q;
	sdl_codes_t           codes_q;
	sdl_state_t           state_d;
	logic [CNT_BITS-1:0]  rise_cnt_d;

	// Edge of a synchronised pin, seen between the second and third flop
	function automatic logic edge_hit(input logic now_v, input logic was_v, input logic rising);
		return rising ? (now_v && !was_v) : (!now_v && was_v);
	endfunction : edge_hit

	wire bclk_rise = edge_hit(bclk_s_q[1], bclk_q, 1'b1); // RL1
	wire le_fall   = edge_hit(le_s_q[1], le_q, 1'b0); // RL4
	wire fire      = (state_q == SDL_WAIT) && bclk_rise
		&& (rise_cnt_q == CNT_BITS'(UPDATE_CLOCKS - 1));

	function automatic sdl_codes_t split_word(input logic [WORD_BITS-1:0] w);
		sdl_codes_t c;
		c.lower_code = '0;
		c.upper_code = '0;
		if (!w[WORD_BITS-1]) begin
			c.lower_code = LOWER_ZERO;
			c.upper_code = w[HALF_BITS-1:0];
		end else begin
			c.lower_code = {1'b0, w[HALF_BITS-1:0]};
			c.upper_code = '0;
		end
		return c;
	endfunction : split_word

	wire sdl_codes_t new_codes = split_word(latched_q); // RL12 RL11

	// Each pin passes two flops; the third stage serves edge detection, and for serial_data it is the bit that is shifted in.
	// Stages clear low so that the strobe shows no false fall after reset; a bit clock held high at reset release shows a false rise.
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			bclk_s_q <= 2'b00;
			bclk_q   <= 1'b0;
		end else begin
			bclk_s_q <= {bclk_s_q[0], bit_clk};
			bclk_q   <= bclk_s_q[1];
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			data_s_q <= 2'b00;
			data_q   <= 1'b0;
		end else begin
			data_s_q <= {data_s_q[0], serial_data};
			data_q   <= data_s_q[1];
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			le_s_q <= 2'b00;
			le_q   <= 1'b0;
		end else begin
			le_s_q <= {le_s_q[0], latch_strobe};
			le_q   <= le_s_q[1];
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) shift_q <= WORD_RESET;
		else if (bclk_rise) shift_q <= {shift_q[WORD_BITS-2:0], data_q}; // RL1 RL2 RL3
	end

	always_ff @(posedge clk) begin
		if (!rst_b) latched_q <= WORD_RESET;
		else if (le_fall) latched_q <= shift_q; // RL4
	end

	// A new strobe fall restarts the count, so the newest word wins
	always_comb begin
		state_d    = state_q;
		rise_cnt_d = rise_cnt_q;
		unique case (state_q)
			SDL_IDLE: begin
				if (le_fall) begin
					state_d    = SDL_WAIT;
					rise_cnt_d = '0;
				end
			end
			SDL_WAIT: begin
				if (le_fall) begin
					rise_cnt_d = '0;
				end else if (fire) begin
					state_d = SDL_IDLE; // RL5
				end else if (bclk_rise) begin
					rise_cnt_d = rise_cnt_q + 1'b1;
				end
			end
			default: begin
				state_d    = SDL_IDLE;
				rise_cnt_d = '0;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			state_q    <= SDL_IDLE;
			rise_cnt_q <= '0;
		end else begin
			state_q    <= state_d;
			rise_cnt_q <= rise_cnt_d;
		end
	end

	// Output register changes only at the update point; bits shifted in
	// meanwhile leave the converter code untouched
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			out_q   <= WORD_RESET;
			codes_q <= split_word(WORD_RESET);
		end else if (fire) begin
			out_q   <= latched_q; // RL13
			codes_q <= new_codes; // RL12
		end
	end

	// The serial side cannot be stalled, so a full buffer loses the update
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			upd_q  <= 1'b0;
			drop_q <= 1'b0;
		end else begin
			upd_q  <= fire; // RL5
			drop_q <= fire && !buf_in_ready;
		end
	end

	sdl_buf2 #(
		.WIDTH ($bits(sdl_codes_t))
	) u_buf (
		.clk       (clk),
		.rst_b     (rst_b),
		.in_valid  (fire),
		.in_ready  (buf_in_ready),
		.in_data   (new_codes),
		.out_valid (buf_out_valid),
		.out_ready (sink_ready),
		.out_data  (buf_out)
	);

	assign current_output = out_q;
	assign lower_code     = codes_q.lower_code;
	assign upper_code     = codes_q.upper_code;
	assign update_pulse   = upd_q;
	assign word_dropped   = drop_q;
endmodule : sdl_loader

// ---- design/sdl_pkg.sv ----
// Package of constants and types for the serial word loader
//
// Operation
// (RL1) Shift data input on each bit-clock rise
// (RL2) Twenty-bit two's-complement word, MSB first
// (RL3) Extra leading bits ignored, last twenty kept
// (RL4) Strobe falling edge copies shift register
// (RL5) Output updates on fourth clock after fall
// (RL6) Sender holds strobe high one cycle first
// (RL7) Sender holds strobe low one cycle after
// (RL8) Stopped clock: strobe low past next first
// (RL9) Sender normally runs the clock continuously
// (RL10) Typical framing: twenty-four slots, last twenty data
// (RL11) 7FFFF positive full, 80000 negative full scale
// (RL12) Split word into two nineteen-bit converter codes; lower_code is twenty bits here
// (RL13) Output holds old code until update point
package sdl_pkg;
	localparam int WORD_BITS     = 20;
	localparam int HALF_BITS     = 19;
	localparam int UPDATE_CLOCKS = 4;
	localparam int CNT_BITS      = 3;
	localparam int CLK_PERIOD_NS = 40;

	localparam logic [WORD_BITS-1:0] WORD_RESET = 20'h0_0000;
	localparam logic [HALF_BITS:0]   LOWER_ZERO = 20'h8_0000;

	typedef struct packed {
		logic [HALF_BITS:0]   lower_code;
		logic [HALF_BITS-1:0] upper_code;
	} sdl_codes_t;

	typedef enum logic [1:0] {
		SDL_IDLE = 2'b00,
		SDL_WAIT = 2'b01
	} sdl_state_t;
endpackage : sdl_pkg

// ---- design/sdl_buf2.sv ----
// Two-entry valid/ready buffer
`timescale 1ns/1ps
module sdl_buf2
	import sdl_pkg::*;
#(
	parameter int WIDTH = 39
) (
	input  wire logic             clk,
	input  wire logic             rst_b,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);
	if (WIDTH < 1) begin : g_bad_width
		$error("WIDTH must be positive");
	end

	logic [WIDTH-1:0] mem_q [2];
	logic             wr_q;
	logic             rd_q;
	logic [1:0]       cnt_q;
	wire              push = in_valid && in_ready;
	wire              pop  = out_valid && out_ready;

	assign in_ready  = cnt_q != 2'd2;
	assign out_valid = cnt_q != 2'd0;
	assign out_data  = mem_q[rd_q];

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			wr_q     <= 1'b0;
			rd_q     <= 1'b0;
			cnt_q    <= 2'd0;
			mem_q[0] <= '0;
			mem_q[1] <= '0;
		end else begin
			if (push) begin
				mem_q[wr_q] <= in_data;
				wr_q        <= ~wr_q;
			end
			if (pop) rd_q <= ~rd_q;
			cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
		end
	end
endmodule : sdl_buf2

// ---- verif/sdl_src.sv ----
// Model of the serial word source
`timescale 1ns/1ps
module sdl_src (
	input wire logic clk,
	output logic bit_clk,
	output logic serial_data,
	output logic latch_strobe
);
	initial begin
		bit_clk = 1'b0;
		serial_data = 1'b0;
		latch_strobe = 1'b1;
	end
	task automatic send(input logic [23:0] w, input int n);
		for (int i = n - 1; i >= 0; i--) begin
			serial_data = w[i];
			repeat (4) @(posedge clk);
			#1 bit_clk = 1'b1;
			repeat (4) @(posedge clk);
			#1 bit_clk = 1'b0;
			if (i == 1) latch_strobe = 1'b1;
		end
		latch_strobe = 1'b0;
	endtask : send
endmodule : sdl_src

// ---- verif/sdl_monitor.sv ----
// Port checker for the serial word loader
`timescale 1ns/1ps
module sdl_monitor (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic bit_clk,
	input wire logic latch_strobe,
	input wire logic [19:0] current_output,
	input wire logic [19:0] lower_code,
	input wire logic [18:0] upper_code,
	input wire logic update_pulse
);
	logic [2:0] n_q;
	// Bit clock rises since the last strobe fall, saturating at seven
	always_ff @(posedge clk) begin
		if (!rst_b)
			n_q <= 3'h7;
		else if ($fell(latch_strobe))
			n_q <= 3'h0;
		else if ($rose(bit_clk) && n_q != 3'h7)
			n_q <= n_q + 3'h1;
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);
	sequence upd_rise_s;
		$rose(update_pulse);
	endsequence
	sequence upd_gone_s;
		##1 !update_pulse;
	endsequence
	pulse_count_a: assert property (upd_rise_s |-> n_q == 3'h4)
		else $error("update clock");
	upd_single_a: assert property (upd_rise_s |-> upd_gone_s)
		else $error("update pulse too long");
	shift_hold_a: assert property (n_q < 3'h4 |-> $stable(current_output))
		else $error("early change");
	out_hold_a: assert property ($changed(current_output) |-> update_pulse)
		else $error("output changed off the update point");
	codes_hold_a: assert property ($changed({lower_code, upper_code}) |-> update_pulse)
		else $error("codes changed off the update point");
	code_map_a: assert property ({lower_code, upper_code} == (current_output[19] ?
		{1'b0, current_output[18:0], 19'h0_0000} : {20'h8_0000, current_output[18:0]}))
		else $error("codes");
endmodule : sdl_monitor
bind sdl_loader sdl_monitor mon_u (
	.clk            (clk),
	.rst_b          (rst_b),
	.bit_clk        (bit_clk),
	.latch_strobe   (latch_strobe),
	.current_output (current_output),
	.lower_code     (lower_code),
	.upper_code     (upper_code),
	.update_pulse   (update_pulse)
);

// ---- verif/sdl_loader_tb.sv ----
// Bench for the serial word loader
`timescale 1ns/1ps
module sdl_loader_tb;
	logic clk = 1'b0, rst_b = 1'b0, sink_ready = 1'b1;
	logic bit_clk, serial_data, latch_strobe, update_pulse, word_dropped;
	logic [19:0] current_output, lower_code;
	logic [18:0] upper_code;
	int bad_count = 0, tests_run = 0, drops = 0, cyc = 0;
	logic [19:0] stale = 20'h0_0000;
	always #20 clk = ~clk;
	sdl_src src_u (
		.clk          (clk),
		.bit_clk      (bit_clk),
		.serial_data  (serial_data),
		.latch_strobe (latch_strobe)
	);
	sdl_loader dut_u (
		.clk            (clk),
		.rst_b          (rst_b),
		.bit_clk        (bit_clk),
		.serial_data    (serial_data),
		.latch_strobe   (latch_strobe),
		.current_output (current_output),
		.lower_code     (lower_code),
		.upper_code     (upper_code),
		.update_pulse   (update_pulse),
		.sink_ready     (sink_ready),
		.word_dropped   (word_dropped)
	);
	always @(posedge clk) begin
		drops <= drops + word_dropped;
		cyc <= cyc + 1;
		if (cyc == 9000) begin
			bad_count++;
			test_done();
		end
	end
	task automatic chk(input logic [19:0] g, e);
		tests_run++;
		if (g !== e) begin
			bad_count++;
			$display("FAIL %0t %h %h", $time, g, e);
		end
	endtask : chk
	task automatic t_word(input logic [19:0] w);
		src_u.send({4'hA, w}, 24);
		chk(current_output, stale);
		src_u.send(24'h00_0000, 5);
		chk(current_output, w);
		chk(lower_code, w[19] ? {1'b0, w[18:0]} : 20'h8_0000);
		chk({1'b0, upper_code}, w[19] ? 20'h0_0000 : {1'b0, w[18:0]});
		// The trailing five zeros leave this word for the next update
		stale = {w[14:0], 5'h00};
	endtask : t_word
	// Reset in mid-run brings back the zero word
	task automatic t_reset();
		rst_b = 1'b0;
		repeat (4) @(posedge clk);
		#1 rst_b = 1'b1;
		repeat (3) @(posedge clk);
		#1;
		stale = 20'h0_0000;
		chk(current_output, 20'h0_0000);
		chk(lower_code, 20'h8_0000);
		chk({1'b0, upper_code}, 20'h0_0000);
	endtask : t_reset
	// Two words with the sink stalled: the last two updates are lost
	task automatic t_stall();
		sink_ready = 1'b0;
		t_word(20'h1_2345);
		t_word(20'hE_DCBA);
		chk(20'(drops), 20'h0_0002);
		sink_ready = 1'b1;
	endtask : t_stall
	task automatic test_done();
		$display("runs %0d bad %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : test_done
	initial begin
		repeat (20) @(posedge clk);
		#1 rst_b = 1'b1;
		repeat (3) @(posedge clk);
		#1;
		t_word(20'h7_FFFF);
		t_word(20'h8_0000);
		t_word(20'h0_0000);
		t_stall();
		t_reset();
		t_word(20'h0_0001);
		test_done();
	end
endmodule : sdl_loader_tb
